/* File: pkg/lbd_regs.vh */
// Constants for the LED backlight dimming control block.
// Assumes an I2C host writes the 8-bit registers and REF_CLK runs at 25 MHz.
// How it works
// RQ1: All dimming timers and counters run from the one fixed block clock.
// RQ2: Resistor select 1 picks external frequency, else 2-bit field picks 312/625/1250 kHz.
// RQ3: On enable, output below 1 V means short; stay disabled.
// RQ4: Then check LED open and over-voltage; soft start only if all pass.
// RQ5: Host waits 2 ms after enable before I2C, then applies input pulses; the bench starts I2C as soon as ACTIVE is high.
// RQ6: Standby bit with external source: input low over 70 ms enters standby.
// RQ7: Adaptive mode starts at output-voltage code, minimum active channel as feedback.
// RQ8: Adaptive: periodic step up below headroom, down above headroom plus hysteresis.
// RQ9: Manual mode drives the output voltage from the output-voltage code.
// RQ10: Source field: 00 external, 01/11 external times register, 10 register duty.
// RQ11: Direct drive bit makes LED output follow the external input.
// RQ12: Method 01 scales amplitude linearly with dimming duty.
// RQ13: Analog mode picks frequency from brightness top byte against two thresholds.
// RQ14: Both threshold registers zero disables automatic frequency selection.
// RQ15: Method 00: amplitude from current code and range, duty follows dimming duty.
// RQ16: Method 10: above transfer point amplitude dims; below, duty scaled by point.
// RQ17: Slope field sets transition time; smoothing field sets transition curvature.
// RQ18: Jitter range bit: 0 gives 1/10, 1 gives 1/16 of frequency.
// RQ19: Rate field 00/01/10 gives 1/100,1/150,1/200; 11 disables jitter.
// RQ20: Duty rise above jump threshold raises output voltage by jump amount.
// RQ21: Two-bit field selects one of three gate-drive strengths.
// RQ22: Three-bit dithering extends the dimming output resolution.
// RQ23: Start-up clears the active bit of every unused channel.
// RQ24: Product duty equals external duty times register duty over full scale.
`ifndef LBD_REGS_VH
`define LBD_REGS_VH
`define LBD_REG_CTRL 4'h0
`define LBD_REG_DIM 4'h1
`define LBD_REG_DUTY_LO 4'h2
`define LBD_REG_DUTY_HI 4'h3
`define LBD_REG_CUR_LO 4'h4
`define LBD_REG_CUR_HI 4'h5
`define LBD_REG_FREQ 4'h6
`define LBD_REG_VOUT 4'h7
`define LBD_REG_HEAD 4'h8
`define LBD_REG_STEP 4'h9
`define LBD_REG_JIT 4'ha
`define LBD_REG_STATUS 8'h0b
`define LBD_REG_AF_LOW 4'hc
`define LBD_REG_AF_HIGH 4'hd
`define LBD_REG_BRIGHT 8'h0e
`define LBD_NUM_CFG 8'h0e
`define LBD_JIT_RST 8'h06
`define LBD_I2C_ADDR 7'h2c
`define LBD_CLK_HZ 25000000
`define LBD_CHK_US 100
`define LBD_SS_US 1000
`define LBD_ADAPT_US 1000
`define LBD_SBY_MS 70
`define LBD_JIT_DIV0 8'h64
`define LBD_JIT_DIV1 8'h96
`define LBD_JIT_DIV2 8'hc8
`endif

/* File: hw/lbd_slew.v */
// Moves a value toward its target one tick at a time.
// Assumes tick is a one-cycle pulse on the same clock.
`default_nettype none
module lbd_slew #(
  parameter W = 12
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire tick,
  input wire [1:0] shape,
  input wire [W-1:0] target,
  output reg [W-1:0] value
);
  wire up = target > value;
  wire [W-1:0] diff = up ? target - value : value - target;
  wire [W-1:0] frac = diff >> shape;
  wire [W-1:0] step = (shape == 2'b00 || frac == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : frac;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      value <= {W{1'b0}};
    // RQ17: linear or curved approach
    else if (ce && tick && diff != {W{1'b0}})
      value <= up ? value + step : value - step;
  end
endmodule
`default_nettype wire

/* File: hw/lbd_i2c.v */
// I2C register slave: pointer write, data write and read with auto-increment.
// Assumes scl and sda are already synchronised to clk.
`include "lbd_regs.vh"
`default_nettype none
module lbd_i2c (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire scl,
  input wire sda,
  input wire [7:0] rdata,
  output reg wr,
  output reg [7:0] ptr,
  output reg [7:0] wdata,
  output wire sda_oe
);
  localparam S_IDLE = 3'd0, S_ADDR = 3'd1, S_ACKA = 3'd2, S_PTR = 3'd3;
  localparam S_ACKP = 3'd4, S_DATA = 3'd5, S_ACKD = 3'd6, S_RD = 3'd7;
  reg [2:0] state;
  reg scl_d, sda_d, rack, rw;
  reg [3:0] bits;
  reg [7:0] sh;
  wire start = scl && scl_d && sda_d && !sda;
  wire stop = scl && scl_d && !sda_d && sda;
  wire rise = scl && !scl_d;
  wire fall = !scl && scl_d;
  wire rx = state == S_ADDR || state == S_PTR || state == S_DATA;
  wire ack = state == S_ACKA || state == S_ACKP || state == S_ACKD;
  assign sda_oe = ack || (state == S_RD && !rack && !sh[7]);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rack <= 1'b0;
      rw <= 1'b0;
      bits <= 4'h0;
      sh <= 8'h00;
      wr <= 1'b0;
      ptr <= 8'h00;
      wdata <= 8'h00;
    end
    else if (ce)
    begin
      scl_d <= scl;
      sda_d <= sda;
      wr <= 1'b0;
      if (start)
      begin
        state <= S_ADDR;
        bits <= 4'h0;
      end
      else if (stop)
        state <= S_IDLE;
      else if (rise && rx)
      begin
        sh <= {sh[6:0], sda};
        bits <= bits + 4'h1;
      end
      else if (rise && state == S_RD && rack && sda)
        state <= S_IDLE;
      else if (fall)
      begin
        case (state)
          S_ADDR:
            if (bits == 4'h8)
            begin
              rw <= sh[0];
              state <= (sh[7:1] == `LBD_I2C_ADDR) ? S_ACKA : S_IDLE;
            end
          S_PTR, S_DATA:
            if (bits == 4'h8)
            begin
              state <= (state == S_PTR) ? S_ACKP : S_ACKD;
              if (state == S_PTR)
                ptr <= sh;
              else
              begin
                wdata <= sh;
                wr <= 1'b1;
              end
            end
          S_ACKA, S_ACKP, S_ACKD:
          begin
            bits <= 4'h0;
            if (state == S_ACKD)
              ptr <= ptr + 8'h01;
            if (state == S_ACKA && rw)
            begin
              state <= S_RD;
              sh <= rdata;
              rack <= 1'b0;
            end
            else
              state <= (state == S_ACKA) ? S_PTR : S_DATA;
          end
          S_RD:
            if (rack)
            begin
              rack <= 1'b0;
              bits <= 4'h0;
              sh <= rdata;
            end
            else if (bits == 4'h7)
            begin
              rack <= 1'b1;
              ptr <= ptr + 8'h01;
            end
            else
            begin
              bits <= bits + 4'h1;
              sh <= {sh[6:0], 1'b0};
            end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/lbd_top.v */
// Digital control of a six-channel LED backlight boost driver.
// Assumes analog comparator results arrive as asynchronous levels on pins.
`include "lbd_regs.vh"
`default_nettype none
module lbd_top #(
  parameter MW = 24,
  parameter CHK_CYC = `LBD_CHK_US * (`LBD_CLK_HZ / 1000000),
  parameter SS_CYC = `LBD_SS_US * (`LBD_CLK_HZ / 1000000),
  parameter ADAPT_CYC = `LBD_ADAPT_US * (`LBD_CLK_HZ / 1000000),
  parameter SBY_CYC = `LBD_SBY_MS * (`LBD_CLK_HZ / 1000)
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire CE,
  input wire EN,
  input wire PWM_IN,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire VOUT_LOW,
  input wire OVP_FAULT,
  input wire [5:0] LED_OPEN,
  input wire [5:0] LED_LOW,
  input wire [5:0] LED_HIGH,
  output reg LED_PWM,
  output wire [11:0] LED_AMP,
  output reg [2:0] MAX_RANGE,
  output reg EXT_DIM_FSET,
  output reg [1:0] FSW_SEL,
  output reg JITTER_EN,
  output reg JITTER_RANGE,
  output reg [7:0] JITTER_DIV,
  output reg [1:0] GATE_DRIVE,
  output reg [7:0] VOUT_CODE,
  output reg [5:0] CH_EN,
  output wire SOFT_START,
  output wire STANDBY,
  output wire FAULT,
  output wire ACTIVE
);
  localparam [2:0] ST_OFF = 3'd0, ST_SHORT = 3'd1, ST_CHECK = 3'd2, ST_SOFT = 3'd3;
  localparam [2:0] ST_RUN = 3'd4, ST_STBY = 3'd5, ST_FAULT = 3'd6;
  localparam [31:0] CHK_W = CHK_CYC - 1;
  localparam [31:0] SS_W = SS_CYC - 1;
  localparam [31:0] AD_W = ADAPT_CYC - 1;
  localparam [31:0] SBY_W = SBY_CYC;
  localparam [MW-1:0] CHK_LIM = CHK_W[MW-1:0];
  localparam [MW-1:0] SS_LIM = SS_W[MW-1:0];
  localparam [MW-1:0] AD_LIM = AD_W[MW-1:0];
  localparam [MW-1:0] SBY_LIM = SBY_W[MW-1:0];
  integer i;

  // Two-flop synchronisers for all pin inputs except RST_N and CE
  reg [23:0] sync1, sync2;
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1 <= 24'h000000;
      sync2 <= 24'h000000;
    end
    else if (CE)
    begin
      sync1 <= {LED_HIGH, LED_LOW, LED_OPEN, OVP_FAULT, VOUT_LOW, SDA_IN, SCL_IN, PWM_IN, EN};
      sync2 <= sync1;
    end
  end
  wire en_s = sync2[0];
  wire pwm_s = sync2[1];
  wire vlow_s = sync2[4];
  wire ovp_s = sync2[5];
  wire [5:0] open_s = sync2[11:6];
  wire [5:0] low_s = sync2[17:12];
  wire [5:0] high_s = sync2[23:18];

  // Register file
  reg [7:0] cfg [0:13];
  reg [2:0] state;
  wire wr;
  wire [7:0] ptr, wdata;
  reg [7:0] rdata;
  wire [11:0] amp_out;
  lbd_i2c u_i2c (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .scl(sync2[2]),
    .sda(sync2[3]),
    .rdata(rdata),
    .wr(wr),
    .ptr(ptr),
    .wdata(wdata),
    .sda_oe(SDA_OE)
  );
  assign SDA_OUT = 1'b0;
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (i = 0; i < 14; i = i + 1)
        cfg[i] <= 8'h00;
      cfg[`LBD_REG_JIT] <= `LBD_JIT_RST;
    end
    else if (CE && wr && ptr < `LBD_NUM_CFG && ptr != `LBD_REG_STATUS)
      cfg[ptr[3:0]] <= wdata;
  end
  always @*
  begin
    if (ptr == `LBD_REG_STATUS)
      rdata = {state == ST_FAULT, state == ST_STBY, CH_EN};
    else if (ptr == `LBD_REG_BRIGHT)
      rdata = amp_out[11:4];
    else if (ptr < `LBD_NUM_CFG)
      rdata = cfg[ptr[3:0]];
    else
      rdata = 8'h00;
  end
  wire [7:0] ctrl = cfg[`LBD_REG_CTRL];
  wire [7:0] dimc = cfg[`LBD_REG_DIM];
  wire [7:0] freq = cfg[`LBD_REG_FREQ];
  wire [7:0] stp = cfg[`LBD_REG_STEP];
  wire [7:0] jit = cfg[`LBD_REG_JIT];
  wire [7:0] lo_th = cfg[`LBD_REG_AF_LOW];
  wire [7:0] hi_th = cfg[`LBD_REG_AF_HIGH];
  wire [15:0] reg_duty = {cfg[`LBD_REG_DUTY_HI], cfg[`LBD_REG_DUTY_LO]};
  wire [11:0] cur_code = {cfg[`LBD_REG_CUR_HI][3:0], cfg[`LBD_REG_CUR_LO]};
  wire [1:0] src = ctrl[7:6];
  wire [1:0] method = dimc[1:0];
  wire [1:0] tsel = dimc[3:2];
  wire standby_on_low_input = ctrl[3];
  wire adaptive = ctrl[4];
  wire direct_input_drive = ctrl[5];

  // External duty measurement with serial divider
  reg pwm_d;
  reg [MW-1:0] hi_cnt, per_cnt, hi_l, per_l, low_cnt;
  reg [MW:0] rem;
  reg [4:0] div_cnt;
  reg [15:0] quo, ext_duty;
  wire per_full = &per_cnt;
  wire [MW+1:0] rem2 = {rem, 1'b0};
  wire ge = rem2 >= {2'b00, per_l};
  wire [15:0] next_quo = {quo[14:0], ge};
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pwm_d <= 1'b0;
      hi_cnt <= {MW{1'b0}};
      per_cnt <= {MW{1'b1}};
      hi_l <= {MW{1'b0}};
      per_l <= {MW{1'b1}};
      low_cnt <= {MW{1'b0}};
      rem <= {(MW+1){1'b0}};
      div_cnt <= 5'd0;
      quo <= 16'h0000;
      ext_duty <= 16'h0000;
    end
    else if (CE)
    begin
      pwm_d <= pwm_s;
      low_cnt <= pwm_s ? {MW{1'b0}} : (&low_cnt ? low_cnt : low_cnt + 1'b1);
      if (pwm_s && !pwm_d)
      begin
        hi_l <= hi_cnt;
        per_l <= per_cnt;
        hi_cnt <= {{(MW-1){1'b0}}, 1'b1};
        per_cnt <= {{(MW-1){1'b0}}, 1'b1};
        rem <= {1'b0, hi_cnt};
        quo <= 16'h0000;
        div_cnt <= per_full ? 5'd0 : 5'd16;
      end
      else
      begin
        per_cnt <= per_full ? per_cnt : per_cnt + 1'b1;
        hi_cnt <= (pwm_s && !per_full) ? hi_cnt + 1'b1 : hi_cnt;
        if (per_full)
          ext_duty <= pwm_s ? 16'hffff : 16'h0000;
        else if (div_cnt != 5'd0)
        begin
          rem <= ge ? rem2[MW:0] - {1'b0, per_l} : rem2[MW:0];
          quo <= next_quo;
          div_cnt <= div_cnt - 5'd1;
          if (div_cnt == 5'd1)
            ext_duty <= (hi_l >= per_l) ? 16'hffff : next_quo;
        end
      end
    end
  end

  // RQ24: product over full scale
  wire [31:0] prod = ext_duty * reg_duty + {16'h0000, reg_duty};
  reg [15:0] dim_duty;
  always @*
  begin
    // RQ10: brightness source select
    case (src)
      2'b00: dim_duty = ext_duty;
      2'b10: dim_duty = reg_duty;
      default: dim_duty = prod[31:16];
    endcase
  end

  // Dimming method: amplitude and duty targets
  wire run = state == ST_RUN;
  wire [15:0] tp = 16'h8000 >> tsel;
  wire [11:0] tp_amp = 12'h800 >> tsel;
  wire [15:0] mix_duty = dim_duty << ({1'b0, tsel} + 3'd1);
  reg [11:0] tgt_amp;
  reg [15:0] tgt_duty;
  always @*
  begin
    tgt_amp = cur_code;
    tgt_duty = dim_duty;
    case (method)
      // RQ12: analog amplitude scaling
      2'b01:
      begin
        tgt_amp = dim_duty[15:4];
        tgt_duty = 16'hffff;
      end
      // RQ16: mix around transfer point
      2'b10:
        if (dim_duty > tp)
        begin
          tgt_amp = dim_duty[15:4];
          tgt_duty = 16'hffff;
        end
        else
        begin
          tgt_amp = tp_amp;
          tgt_duty = mix_duty;
        end
      // RQ15: fixed amplitude, duty follows
      default:
      begin
        tgt_amp = cur_code;
        tgt_duty = dim_duty;
      end
    endcase
    if (!run)
    begin
      tgt_amp = 12'h000;
      tgt_duty = 16'h0000;
    end
  end

  // RQ1: shared timer prescaler
  reg [15:0] pre;
  wire [15:0] slope_mask = (16'h0010 << dimc[6:4]) - 16'h0001;
  wire slew_tick = (pre & slope_mask) == 16'h0000;
  wire [15:0] duty_out;
  lbd_slew #(.W(12)) u_amp (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .tick(slew_tick),
    .shape(freq[5:4]),
    .target(tgt_amp),
    .value(amp_out)
  );
  lbd_slew #(.W(16)) u_duty (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .tick(slew_tick),
    .shape(freq[5:4]),
    .target(tgt_duty),
    .value(duty_out)
  );
  assign LED_AMP = amp_out;

  // Dithered PWM generator
  reg [3:0] fdiv;
  reg [12:0] pcnt;
  reg [2:0] frame;
  wire [13:0] cmp = {1'b0, duty_out[15:3]} + {13'h0000, frame < duty_out[2:0]};
  wire pwm_on = duty_out == 16'hffff || {1'b0, pcnt} < cmp;
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pre <= 16'h0000;
      fdiv <= 4'h0;
      pcnt <= 13'h0000;
      frame <= 3'd0;
      LED_PWM <= 1'b0;
    end
    else if (CE)
    begin
      pre <= pre + 16'h0001;
      fdiv <= (fdiv == 4'h0) ? freq[3:0] : fdiv - 4'h1;
      if (fdiv == 4'h0)
      begin
        pcnt <= pcnt + 13'h0001;
        // RQ22: three-bit frame dither
        if (&pcnt)
          frame <= frame + 3'd1;
      end
      // RQ11: direct input drive
      LED_PWM <= direct_input_drive ? (run && pwm_s) : (run && pwm_on);
    end
  end

  // Start-up, standby and output voltage control
  reg [MW-1:0] tmr, atmr;
  reg [15:0] duty_prev;
  wire low_any = |(low_s & CH_EN);
  wire high_all = (&(high_s | ~CH_EN)) && (|CH_EN);
  wire jump = dim_duty > duty_prev && (dim_duty - duty_prev) > (16'h1000 << stp[5:4]);
  wire [8:0] up_sum = {1'b0, VOUT_CODE} + {1'b0, 8'h01 << stp[1:0]};
  wire [8:0] dn_dif = {1'b0, VOUT_CODE} - {1'b0, 8'h01 << stp[3:2]};
  wire [8:0] jp_sum = {1'b0, VOUT_CODE} + {1'b0, 8'h04 << stp[7:6]};
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ST_OFF;
      tmr <= {MW{1'b0}};
      atmr <= {MW{1'b0}};
      CH_EN <= 6'h3f;
      VOUT_CODE <= 8'h00;
      duty_prev <= 16'h0000;
    end
    else if (CE)
    begin
      duty_prev <= dim_duty;
      tmr <= tmr + 1'b1;
      if (!en_s)
      begin
        state <= ST_OFF;
        VOUT_CODE <= 8'h00;
      end
      else
        case (state)
          ST_OFF:
          begin
            state <= ST_SHORT;
            tmr <= {MW{1'b0}};
          end
          // RQ3: output short check
          ST_SHORT:
            if (tmr == CHK_LIM)
            begin
              state <= vlow_s ? ST_FAULT : ST_CHECK;
              tmr <= {MW{1'b0}};
            end
          // RQ4: open and over-voltage check
          ST_CHECK:
            if (tmr == CHK_LIM)
            begin
              // RQ23: drop unused channels
              CH_EN <= ~open_s;
              state <= ((&open_s) || ovp_s) ? ST_FAULT : ST_SOFT;
              tmr <= {MW{1'b0}};
              // RQ7: start at target code
              VOUT_CODE <= cfg[`LBD_REG_VOUT];
            end
          ST_SOFT:
            if (tmr == SS_LIM)
            begin
              state <= ST_RUN;
              atmr <= {MW{1'b0}};
            end
          ST_RUN:
          begin
            atmr <= (atmr == AD_LIM) ? {MW{1'b0}} : atmr + 1'b1;
            // RQ6: standby on long low input
            if (standby_on_low_input && src == 2'b00 && low_cnt > SBY_LIM)
              state <= ST_STBY;
            // RQ20: voltage jump on duty rise
            else if (jump)
              VOUT_CODE <= jp_sum[8] ? 8'hff : jp_sum[7:0];
            else if (atmr == AD_LIM)
            begin
              // RQ8: periodic headroom stepping
              if (adaptive && low_any)
                VOUT_CODE <= up_sum[8] ? 8'hff : up_sum[7:0];
              else if (adaptive && high_all)
                VOUT_CODE <= dn_dif[8] ? 8'h00 : dn_dif[7:0];
              // RQ9: manual code
              else if (!adaptive)
                VOUT_CODE <= cfg[`LBD_REG_VOUT];
            end
          end
          ST_STBY:
          begin
            VOUT_CODE <= 8'h00;
            if (pwm_s)
            begin
              state <= ST_SHORT;
              tmr <= {MW{1'b0}};
            end
          end
          ST_FAULT:
            VOUT_CODE <= 8'h00;
          default:
            state <= ST_OFF;
        endcase
    end
  end
  assign SOFT_START = state == ST_SOFT;
  assign STANDBY = state == ST_STBY;
  assign FAULT = state == ST_FAULT;
  assign ACTIVE = run;

  // Switching frequency, jitter and gate drive settings
  wire auto_on = method == 2'b01 && !(lo_th == 8'h00 && hi_th == 8'h00);
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      FSW_SEL <= 2'b00;
      JITTER_EN <= 1'b0;
      JITTER_RANGE <= 1'b0;
      JITTER_DIV <= `LBD_JIT_DIV0;
      GATE_DRIVE <= 2'b00;
      MAX_RANGE <= 3'd0;
      EXT_DIM_FSET <= 1'b0;
    end
    else if (CE)
    begin
      // RQ13: automatic selection; RQ14: zero thresholds disable it
      if (auto_on)
        FSW_SEL <= (amp_out[11:4] < lo_th) ? 2'b00 : (amp_out[11:4] > hi_th) ? 2'b10 : 2'b01;
      // RQ2: resistor or register frequency
      else if (ctrl[0])
        FSW_SEL <= 2'b11;
      else
        FSW_SEL <= (ctrl[2:1] == 2'b11) ? 2'b10 : ctrl[2:1];
      // RQ18: jitter range
      JITTER_RANGE <= jit[0];
      // RQ19: modulation rate
      JITTER_EN <= jit[2:1] != 2'b11;
      JITTER_DIV <= (jit[2:1] == 2'b01) ? `LBD_JIT_DIV1 :
                    (jit[2:1] == 2'b10) ? `LBD_JIT_DIV2 : `LBD_JIT_DIV0;
      // RQ21: three drive strengths
      GATE_DRIVE <= (freq[7:6] == 2'b11) ? 2'b10 : freq[7:6];
      MAX_RANGE <= cfg[`LBD_REG_CUR_HI][6:4];
      EXT_DIM_FSET <= dimc[7];
    end
  end
endmodule
`default_nettype wire

/* File: hw/lbd_dummy_unused.v */
// Intentionally empty.
`default_nettype none
`default_nettype wire

/* File: bench/lbd_sva.sv */
// Assertions on the dimming control top-level ports.
// Assumes CE stays high while bound to lbd_top.
`default_nettype none
module lbd_sva_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic EN,
  input wire logic LED_PWM,
  input wire logic JITTER_EN,
  input wire logic [7:0] JITTER_DIV,
  input wire logic [1:0] GATE_DRIVE,
  input wire logic [5:0] CH_EN,
  input wire logic SOFT_START,
  input wire logic STANDBY,
  input wire logic FAULT,
  input wire logic ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence en_low_s;
    !EN [*5];
  endsequence
  jit_div_a: assert property (JITTER_EN |-> JITTER_DIV inside {8'h64, 8'h96, 8'hc8})
    else $error("Jitter divider outside its set");
  gate_lim_a: assert property (GATE_DRIVE != 2'h3)
    else $error("Gate drive code 3 driven");
  fault_quiet_a: assert property (FAULT |-> !SOFT_START && !ACTIVE)
    else $error("Running while in fault");
  en_off_a: assert property (en_low_s |-> !FAULT && !SOFT_START && !ACTIVE)
    else $error("Not off after enable low");
  ss_chan_a: assert property (SOFT_START |-> CH_EN != 6'h00)
    else $error("Soft start with no channel");
  act_after_a: assert property ($rose(ACTIVE) |-> $past(SOFT_START))
    else $error("Active without soft start");
  chan_hold_a: assert property (ACTIVE && $past(ACTIVE) |-> $stable(CH_EN))
    else $error("Channel enables moved while active");
  stby_dark_a: assert property (STANDBY |-> !SOFT_START ##1 !LED_PWM)
    else $error("Output live in standby");
endmodule
bind lbd_top lbd_sva_chk i_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .EN(EN), .LED_PWM(LED_PWM), .JITTER_EN(JITTER_EN),
  .JITTER_DIV(JITTER_DIV), .GATE_DRIVE(GATE_DRIVE), .CH_EN(CH_EN),
  .SOFT_START(SOFT_START), .STANDBY(STANDBY), .FAULT(FAULT), .ACTIVE(ACTIVE)
);
`default_nettype wire

/* File: bench/lbd_host_model.sv */
// I2C host and external brightness pulse source.
// Assumes an open-drain sda with pull-up built by the bench.
`include "lbd_regs.vh"
`default_nettype none
module lbd_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_lo,
  output logic pwm
);
  timeunit 1ns;
  timeprecision 1ps;
  int nak = 0;
  int per = 1;
  int hi = 0;
  int cnt = 0;
  initial
  begin
    scl = 1'b1;
    sda_lo = 1'b0;
    pwm = 1'b0;
  end
  always @(negedge clk)
  begin
    cnt <= (cnt + 1 >= per) ? 0 : cnt + 1;
    pwm <= (cnt < hi);
  end
  task automatic w2;
    repeat (2) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_lo = !b;
    w2;
    scl = 1'b1;
    w2;
    r = sda;
    w2;
    scl = 1'b0;
    w2;
  endtask
  task automatic start;
    sda_lo = 1'b0;
    w2;
    scl = 1'b1;
    w2;
    sda_lo = 1'b1;
    w2;
    scl = 1'b0;
    w2;
  endtask
  task automatic stop;
    sda_lo = 1'b1;
    w2;
    scl = 1'b1;
    w2;
    sda_lo = 1'b0;
    repeat (14) @(negedge clk);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ma, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    logic a0, a1, a2;
    start;
    xfer({`LBD_I2C_ADDR, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop;
    nak += a0 + a1 + a2;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    logic a0, a1, a2, a3;
    start;
    xfer({`LBD_I2C_ADDR, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    start;
    xfer({`LBD_I2C_ADDR, 1'b1}, 1'b1, q, a2);
    xfer(8'hff, 1'b1, q, a3);
    stop;
    nak += a0 + a1 + a2;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_led_backlight_dimming_control.sv */
// Self-checking bench for the LED backlight dimming control.
// Assumes lbd_top, its header, checker and host model compile first.
`include "lbd_regs.vh"
`default_nettype none
module tb_led_backlight_dimming_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic EN = 1'b0;
  logic CE = 1'b1;
  logic VOUT_LOW = 1'b0;
  logic OVP_FAULT = 1'b0;
  logic [5:0] LED_OPEN = 6'h00;
  logic [5:0] LED_LOW = 6'h00;
  logic [5:0] LED_HIGH = 6'h00;
  logic [7:0] q;
  logic a;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire logic SDA_OUT, SDA_OE, LED_PWM, JITTER_EN, JITTER_RANGE, SOFT_START;
  wire logic STANDBY, FAULT, ACTIVE, EXT_DIM_FSET, scl, hsda, pwm;
  wire logic [1:0] FSW_SEL, GATE_DRIVE;
  wire logic [2:0] MAX_RANGE;
  wire logic [5:0] CH_EN;
  wire logic [7:0] JITTER_DIV, VOUT_CODE;
  wire logic sda = (SDA_OE ? SDA_OUT : 1'b1) & !hsda;
  lbd_top #(.MW(16), .CHK_CYC(4), .SS_CYC(8), .ADAPT_CYC(16), .SBY_CYC(200)) i_dut (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .EN(EN), .PWM_IN(pwm), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .VOUT_LOW(VOUT_LOW),
    .OVP_FAULT(OVP_FAULT), .LED_OPEN(LED_OPEN), .LED_LOW(LED_LOW), .LED_HIGH(LED_HIGH),
    .LED_PWM(LED_PWM), .LED_AMP(), .MAX_RANGE(MAX_RANGE), .EXT_DIM_FSET(EXT_DIM_FSET),
    .FSW_SEL(FSW_SEL), .JITTER_EN(JITTER_EN), .JITTER_RANGE(JITTER_RANGE),
    .JITTER_DIV(JITTER_DIV), .GATE_DRIVE(GATE_DRIVE), .VOUT_CODE(VOUT_CODE),
    .CH_EN(CH_EN), .SOFT_START(SOFT_START), .STANDBY(STANDBY), .FAULT(FAULT), .ACTIVE(ACTIVE)
  );
  lbd_host_model i_host (.clk(REF_CLK), .sda(sda), .scl(scl), .sda_lo(hsda), .pwm(pwm));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask
  task automatic wait_act;
    for (int i = 0; i < 200 && ACTIVE !== 1'b1; i++)
      wt(1);
  endtask
  initial
  begin
    forever #20 REF_CLK = !REF_CLK;
  end
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      end_sim;
    end
  end
  initial
  begin
    wt(5);
    chk(CH_EN, 6'h3f);
    chk(JITTER_EN, 1'b0);
    RST_N = 1'b1;
    VOUT_LOW = 1'b1;
    EN = 1'b1;
    wt(20);
    chk(FAULT, 1'b1);
    EN = 1'b0;
    VOUT_LOW = 1'b0;
    OVP_FAULT = 1'b1;
    wt(6);
    EN = 1'b1;
    wt(20);
    chk(FAULT, 1'b1);
    EN = 1'b0;
    OVP_FAULT = 1'b0;
    LED_OPEN = 6'h05;
    wt(6);
    EN = 1'b1;
    wait_act;
    chk(ACTIVE, 1'b1);
    chk(CH_EN, 6'h3a);
    $display("Test startup done");
    for (int r = 0; r < 8; r++)
    begin
      i_host.wr(`LBD_REG_CTRL, {5'h00, r[1:0], 1'b0});
      i_host.wr(`LBD_REG_FREQ, {r[1:0], 6'h00});
      i_host.wr(`LBD_REG_JIT, {5'h00, r[2:0]});
      wt(4);
      chk(FSW_SEL, r[1:0] == 3 ? 2 : r[1:0]);
      chk(GATE_DRIVE, r[1:0] == 3 ? 2 : r[1:0]);
      chk(JITTER_EN, r[2:1] != 3);
      chk(JITTER_RANGE, r[0]);
      if (r[2:1] != 3)
        chk(JITTER_DIV, r[2:1] == 0 ? 8'h64 : r[2:1] == 1 ? 8'h96 : 8'hc8);
    end
    i_host.wr(`LBD_REG_CTRL, 8'h01);
    i_host.wr(`LBD_REG_CUR_HI, 8'h50);
    wt(4);
    chk(FSW_SEL, 2'h3);
    chk(MAX_RANGE, 3'h5);
    $display("Test fields done");
    i_host.wr(`LBD_REG_CTRL, 8'h84);
    i_host.wr(`LBD_REG_DIM, 8'h81);
    i_host.wr(`LBD_REG_AF_LOW, 8'h12);
    i_host.wr(`LBD_REG_AF_HIGH, 8'h34);
    i_host.rd(`LBD_REG_AF_LOW, q);
    chk(q, 8'h12);
    i_host.rd(`LBD_REG_AF_HIGH, q);
    chk(q, 8'h34);
    chk(FSW_SEL, 2'h0);
    chk(EXT_DIM_FSET, 1'b1);
    i_host.wr(`LBD_REG_AF_LOW, 8'h00);
    i_host.wr(`LBD_REG_AF_HIGH, 8'h00);
    wt(4);
    chk(FSW_SEL, 2'h2);
    i_host.wr(`LBD_REG_STATUS, 8'hff);
    i_host.rd(`LBD_REG_STATUS, q);
    chk(q, 8'h3a);
    i_host.wr(`LBD_REG_VOUT, 8'h5a);
    wt(40);
    chk(VOUT_CODE, 8'h5a);
    $display("Test registers done");
    i_host.wr(`LBD_REG_CTRL, 8'h20);
    i_host.hi = 1;
    wt(10);
    chk(LED_PWM, 1'b1);
    i_host.hi = 0;
    wt(10);
    chk(LED_PWM, 1'b0);
    i_host.hi = 1;
    i_host.wr(`LBD_REG_CTRL, 8'h08);
    i_host.hi = 0;
    wt(150);
    chk(STANDBY, 1'b0);
    wt(100);
    chk(STANDBY, 1'b1);
    i_host.hi = 1;
    wt(10);
    chk(STANDBY, 1'b0);
    wait_act;
    chk(ACTIVE, 1'b1);
    i_host.start;
    i_host.xfer(8'h90, 1'b1, q, a);
    i_host.stop;
    chk(a, 1'b1);
    chk(i_host.nak, 0);
    chk(VOUT_CODE, 8'h5a);
    $display("Test drive and standby done");
    i_host.wr(`LBD_REG_CTRL, 8'h10);
    LED_LOW = 6'h02;
    for (int i = 0; i < 40 && VOUT_CODE !== 8'h5b; i++)
      wt(1);
    chk(VOUT_CODE, 8'h5b);
    CE = 1'b0;
    LED_LOW = 6'h00;
    LED_HIGH = 6'h3f;
    wt(20);
    chk(VOUT_CODE, 8'h5b);
    CE = 1'b1;
    wt(16);
    chk(VOUT_CODE, 8'h5a);
    $display("Test adaptive done");
    end_sim;
  end
endmodule
`default_nettype wire
